//--- tg_cfg.svh
`ifndef TG_CFG_SVH
`define TG_CFG_SVH

// widths
`define TG_TMR_W         16
`define TG_REG_W         16
`define TG_CTRL_W        10
`define TG_ADR_W         8
`define TG_DAT_W         32
`define TG_SEL_W         4

// register byte offsets
`define TG_OFF_CTRL_A    8'h00
`define TG_OFF_CTRL_CORE 8'h04
`define TG_OFF_CTRL_B    8'h08
`define TG_OFF_CNT_A     8'h0C
`define TG_OFF_CNT_CORE  8'h10
`define TG_OFF_CNT_B     8'h14
`define TG_OFF_STATUS    8'h18

// control register fields
`define TG_F_SEL_LO      0
`define TG_F_SEL_HI      2
`define TG_F_MODE_LO     3
`define TG_F_MODE_HI     5
`define TG_F_RUN         6
`define TG_F_DOWN        7
`define TG_F_EXTDIR      8
`define TG_F_OUTEN       9

// status register fields
`define TG_ST_LATCH      0
`define TG_ST_WRAP_LO    1
`define TG_ST_WRAP_HI    3

// mode codes
`define TG_MODE_TIMER     3'h0
`define TG_MODE_COUNTER   3'h1
`define TG_MODE_GATE_LOW  3'h2
`define TG_MODE_GATE_HIGH 3'h3
`define TG_MODE_RELOAD    3'h4
`define TG_MODE_CAPTURE   3'h5
`define TG_MODE_INCR      3'h6

// prescaler: code 0 divides by 2**3, code 7 by 2**10
`define TG_PS_BASE_LOG2  3
`define TG_PS_CODES      8
`define TG_PS_W          10

// timer indices
`define TG_IDX_A         0
`define TG_IDX_CORE      1
`define TG_IDX_B         2

// reset values
`define TG_CTRL_RST      10'h000
`define TG_CNT_RST       16'h0000
`define TG_LATCH_RST     1'b0

`endif

//--- tg_pkg.sv
`default_nettype none
`include "tg_cfg.svh"

package tg_pkg;

    typedef enum logic [2:0] {
        TG_M_TIMER     = `TG_MODE_TIMER,
        TG_M_COUNTER   = `TG_MODE_COUNTER,
        TG_M_GATE_LOW  = `TG_MODE_GATE_LOW,
        TG_M_GATE_HIGH = `TG_MODE_GATE_HIGH,
        TG_M_RELOAD    = `TG_MODE_RELOAD,
        TG_M_CAPTURE   = `TG_MODE_CAPTURE,
        TG_M_INCR      = `TG_MODE_INCR
    } tg_mode_t;

    typedef logic [`TG_CTRL_W-1:0] tg_ctrl_t;

endpackage : tg_pkg

`default_nettype wire

//--- tg_timer_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "tg_cfg.svh"

module tg_timer_unit
    import tg_pkg::*;
#(
    parameter int W = `TG_TMR_W
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // configuration and prescaled tick
    input  wire tg_ctrl_t     ctrl,
    input  wire logic         ps_tick,
    // synchronised count/gate pin and direction pin
    input  wire logic         pin_lvl,
    input  wire logic         pin_rise,
    input  wire logic         pin_fall,
    input  wire logic         dir_lvl,
    input  wire logic         dir_rise,
    input  wire logic         dir_fall,
    // internal count source
    input  wire logic         int_rise,
    input  wire logic         int_fall,
    // parallel load
    input  wire logic         load_en,
    input  wire logic [W-1:0] load_val,
    // state
    output logic [W-1:0]      value_q,
    output logic              ovf,
    output logic              unf
);

    if (W < 2) begin : g_bad_w
        $error("tg_timer_unit: W must be at least 2");
    end

    tg_mode_t   mode;
    logic [2:0] sel;
    logic       step;
    logic       down;
    logic       q_up;
    logic       a_edge;
    logic       b_edge;
    logic       ext_rise;
    logic       ext_fall;

    assign mode   = tg_mode_t'(ctrl[`TG_F_MODE_HI:`TG_F_MODE_LO]);
    assign sel    = ctrl[`TG_F_SEL_HI:`TG_F_SEL_LO];
    assign a_edge = pin_rise | pin_fall;
    assign b_edge = dir_rise | dir_fall;
    // top select bit swaps the pin for the internal source
    assign ext_rise = sel[2] ? int_rise : pin_rise;
    assign ext_fall = sel[2] ? int_fall : pin_fall;
    // after an A edge the tracks differ when moving up, after a B edge they agree
    assign q_up = a_edge ? (pin_lvl != dir_lvl) : (pin_lvl == dir_lvl);

    always_comb begin
        step = 1'b0;
        down = ctrl[`TG_F_DOWN] ^ (ctrl[`TG_F_EXTDIR] & dir_lvl);
        if (ctrl[`TG_F_RUN]) begin
            case (mode)
                TG_M_TIMER:     step = ps_tick;
                TG_M_GATE_LOW:  step = ps_tick & ~pin_lvl;
                TG_M_GATE_HIGH: step = ps_tick & pin_lvl;
                TG_M_COUNTER:   step = (sel[0] & ext_rise) | (sel[1] & ext_fall);
                TG_M_INCR: begin
                    step = (sel[0] & a_edge) | (sel[1] & b_edge);
                    down = ~q_up ^ ctrl[`TG_F_DOWN];
                end
                default:        step = 1'b0;
            endcase
        end
    end

    assign ovf = step & ~down & (value_q == {W{1'b1}});
    assign unf = step & down & (value_q == {W{1'b0}});

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            value_q <= W'(`TG_CNT_RST);
        end else if (load_en) begin
            value_q <= load_val;
        end else if (step) begin
            value_q <= down ? value_q - 1'b1 : value_q + 1'b1;
        end
    end

    AST_WRAP_UP: assert property (
        @(posedge clk) disable iff (!rst_n)
        ovf && !load_en |=> value_q == {W{1'b0}})
        else $error("up count from all ones did not wrap to zero");

    AST_WRAP_DOWN: assert property (
        @(posedge clk) disable iff (!rst_n)
        unf && !load_en |=> value_q == {W{1'b1}} && $past(value_q) == {W{1'b0}})
        else $error("down count from zero did not wrap to all ones");

    AST_STOPPED: assert property (
        @(posedge clk) disable iff (!rst_n)
        (mode == TG_M_RELOAD || mode == TG_M_CAPTURE) && !load_en |=> $stable(value_q))
        else $error("timer counted while used as capture or reload register");

endmodule : tg_timer_unit

`default_nettype wire

//--- tg_timer_group_one.sv
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tg_cfg.svh"

module tg_timer_group_one
    import tg_pkg::*;
#(
    parameter int W = `TG_TMR_W
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // wishbone classic slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [`TG_ADR_W-1:0]  wb_adr_i,
    input  wire logic [`TG_SEL_W-1:0]  wb_sel_i,
    input  wire logic [`TG_DAT_W-1:0]  wb_dat_i,
    output logic      [`TG_DAT_W-1:0]  wb_dat_o,
    output logic                       wb_ack_o,
    // timer pins: index 0 aux a, 1 core, 2 aux b
    input  wire logic [2:0]            timer_count_gate_input,
    input  wire logic [2:0]            timer_direction_input,
    output logic                       toggle_latch_output_pin
);

    localparam int NT = 3;
    localparam int NP = 2 * NT;
    localparam int IA = `TG_IDX_A;
    localparam int IC = `TG_IDX_CORE;
    localparam int IB = `TG_IDX_B;
    localparam logic [`TG_ADR_W-1:0] CTRL_OFF [NT] =
        '{`TG_OFF_CTRL_A, `TG_OFF_CTRL_CORE, `TG_OFF_CTRL_B};
    localparam logic [`TG_ADR_W-1:0] CNT_OFF [NT] =
        '{`TG_OFF_CNT_A, `TG_OFF_CNT_CORE, `TG_OFF_CNT_B};

    if (W < 2 || W > `TG_REG_W) begin : g_bad_w
        $error("tg_timer_group_one: W must lie between 2 and the register width");
    end

    function automatic logic [`TG_REG_W-1:0] merge16(
        input logic [`TG_REG_W-1:0] old_v,
        input logic [`TG_REG_W-1:0] new_v,
        input logic [1:0]           lanes
    );
        merge16 = {lanes[1] ? new_v[15:8] : old_v[15:8],
                   lanes[0] ? new_v[7:0]  : old_v[7:0]};
    endfunction : merge16

    // ---------------- pin synchronisers ----------------
    logic [NP-1:0] raw_pins;
    logic [NP-1:0] sync1_q;
    logic [NP-1:0] sync2_q;
    logic [NP-1:0] sync3_q;
    logic [NP-1:0] pin_rise;
    logic [NP-1:0] pin_fall;

    assign raw_pins = {timer_direction_input, timer_count_gate_input};

    // third stage only feeds the edge detectors, never the first stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= raw_pins;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign pin_rise = sync2_q & ~sync3_q;
    assign pin_fall = ~sync2_q & sync3_q;

    // ---------------- shared prescaler ----------------
    logic [`TG_PS_W-1:0]     ps_q;
    logic [`TG_PS_CODES-1:0] ps_tick;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ps_q <= '0;
        end else begin
            ps_q <= ps_q + 1'b1;
        end
    end

    for (genvar c = 0; c < `TG_PS_CODES; c++) begin : g_ps
        assign ps_tick[c] = &ps_q[c + `TG_PS_BASE_LOG2 - 1:0];
    end

    // ---------------- wishbone slave ----------------
    logic                 req;
    logic                 wr_fire;
    logic                 ack_q;
    logic                 wr_stat;
    logic [`TG_DAT_W-1:0] rd_data;
    logic [`TG_DAT_W-1:0] dat_q;
    logic [NT-1:0]        wr_ctrl;
    logic [NT-1:0]        wr_cnt;

    assign req     = wb_cyc_i & wb_stb_i;
    // writes land on the edge where the master sees ack
    assign wr_fire = req & wb_we_i & ack_q;
    assign wr_stat = wr_fire & (wb_adr_i == `TG_OFF_STATUS);

    // ---------------- timers ----------------
    tg_ctrl_t      ctrl_q [NT];
    logic [W-1:0]  cnt    [NT];
    logic [W-1:0]  ld_val [NT];
    logic [NT-1:0] ld_en;
    logic [NT-1:0] ovf;
    logic [NT-1:0] unf;
    logic [NT-1:0] wrap;
    logic [NT-1:0] int_rise;
    logic [NT-1:0] int_fall;
    logic [NT-1:0] capture;
    logic [NT-1:0] reload;
    logic          latch_q;
    logic          lat_prev_q;
    logic          lat_rise;
    logic          lat_fall;
    logic          pin_q;
    logic [NT-1:0] wrap_q;

    assign wrap     = ovf | unf;
    // registered latch edges break the loop core wrap -> latch -> aux -> core
    assign lat_rise = latch_q & ~lat_prev_q;
    assign lat_fall = ~latch_q & lat_prev_q;

    for (genvar i = 0; i < NT; i++) begin : g_tmr
        tg_mode_t   mode;
        logic [2:0] sel;
        logic       pin_trig;
        logic       lat_trig;

        assign mode     = tg_mode_t'(ctrl_q[i][`TG_F_MODE_HI:`TG_F_MODE_LO]);
        assign sel      = ctrl_q[i][`TG_F_SEL_HI:`TG_F_SEL_LO];
        assign pin_trig = (sel[0] & pin_rise[i]) | (sel[1] & pin_fall[i]);
        assign lat_trig = (sel[0] & lat_rise) | (sel[1] & lat_fall);
        assign wr_ctrl[i] = wr_fire & (wb_adr_i == CTRL_OFF[i]);
        assign wr_cnt[i]  = wr_fire & (wb_adr_i == CNT_OFF[i]);

        if (i == IC) begin : g_core
            // core chains on aux a wraps (sel 0) or aux b wraps (sel 1)
            assign int_rise[i] = wrap[IA];
            assign int_fall[i] = wrap[IB];
            assign capture[i]  = 1'b0;
            assign reload[i]   = 1'b0;
            assign ld_en[i]    = wr_cnt[i] | reload[IA] | reload[IB];
            // aux a wins when both reload in the same cycle
            assign ld_val[i]   = wr_cnt[i] ? W'(merge16(`TG_REG_W'(cnt[i]),
                                     wb_dat_i[`TG_REG_W-1:0], wb_sel_i[1:0]))
                               : reload[IA] ? cnt[IA] : cnt[IB];
        end else begin : g_aux
            assign int_rise[i] = lat_rise;
            assign int_fall[i] = lat_fall;
            assign capture[i]  = (mode == TG_M_CAPTURE) & pin_trig;
            assign reload[i]   = (mode == TG_M_RELOAD)
                                 & (sel[2] ? lat_trig : pin_trig);
            assign ld_en[i]    = wr_cnt[i] | capture[i];
            assign ld_val[i]   = wr_cnt[i] ? W'(merge16(`TG_REG_W'(cnt[i]),
                                     wb_dat_i[`TG_REG_W-1:0], wb_sel_i[1:0]))
                               : cnt[IC];
        end

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                ctrl_q[i] <= `TG_CTRL_RST;
            end else if (wr_ctrl[i]) begin
                ctrl_q[i] <= tg_ctrl_t'(merge16(`TG_REG_W'(ctrl_q[i]),
                                 wb_dat_i[`TG_REG_W-1:0], wb_sel_i[1:0]));
            end
        end

        tg_timer_unit #(
            .W (W)
        ) u_tmr (
            .clk      (clk),
            .rst_n    (rst_n),
            .ctrl     (ctrl_q[i]),
            .ps_tick  (ps_tick[sel]),
            .pin_lvl  (sync2_q[i]),
            .pin_rise (pin_rise[i]),
            .pin_fall (pin_fall[i]),
            .dir_lvl  (sync2_q[NT + i]),
            .dir_rise (pin_rise[NT + i]),
            .dir_fall (pin_fall[NT + i]),
            .int_rise (int_rise[i]),
            .int_fall (int_fall[i]),
            .load_en  (ld_en[i]),
            .load_val (ld_val[i]),
            .value_q  (cnt[i]),
            .ovf      (ovf[i]),
            .unf      (unf[i])
        );
    end

    // ---------------- toggle latch and status ----------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latch_q    <= `TG_LATCH_RST;
            lat_prev_q <= `TG_LATCH_RST;
        end else begin
            // a wrap in the cycle of a software write still flips the written value
            latch_q    <= ((wr_stat & wb_sel_i[0]) ? wb_dat_i[`TG_ST_LATCH] : latch_q)
                          ^ wrap[IC];
            lat_prev_q <= latch_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrap_q <= '0;
        end else if (wr_stat & wb_sel_i[0]) begin
            // write one to clear; a new wrap wins over the clear
            wrap_q <= (wrap_q & ~wb_dat_i[`TG_ST_WRAP_HI:`TG_ST_WRAP_LO]) | wrap;
        end else begin
            wrap_q <= wrap_q | wrap;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_q <= `TG_LATCH_RST;
        end else begin
            pin_q <= latch_q & ctrl_q[IC][`TG_F_OUTEN];
        end
    end

    assign toggle_latch_output_pin = pin_q;

    // ---------------- read path and ack ----------------
    always_comb begin
        rd_data = '0;
        for (int k = 0; k < NT; k++) begin
            if (wb_adr_i == CTRL_OFF[k]) begin
                rd_data[`TG_CTRL_W-1:0] = ctrl_q[k];
            end
            if (wb_adr_i == CNT_OFF[k]) begin
                rd_data[W-1:0] = cnt[k];
            end
        end
        if (wb_adr_i == `TG_OFF_STATUS) begin
            rd_data[`TG_ST_LATCH]                  = latch_q;
            rd_data[`TG_ST_WRAP_HI:`TG_ST_WRAP_LO] = wrap_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= req & ~ack_q;
            if (req & ~ack_q) begin
                dat_q <= rd_data;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // ---------------- checks ----------------
    AST_ACK_ONE: assert property (
        @(posedge clk) disable iff (!rst_n)
        ack_q |=> !ack_q)
        else $error("ack stood longer than one cycle");

    AST_TOGGLE: assert property (
        @(posedge clk) disable iff (!rst_n)
        wrap[IC] && !wr_stat |=> latch_q != $past(latch_q))
        else $error("core wrap did not flip the toggle latch");

    AST_CAPTURE: assert property (
        @(posedge clk) disable iff (!rst_n)
        capture[IA] && !wr_cnt[IA] |=> cnt[IA] == $past(cnt[IC]))
        else $error("aux a did not capture the core value");

    AST_RELOAD: assert property (
        @(posedge clk) disable iff (!rst_n)
        reload[IA] && !wr_cnt[IC] |=> cnt[IC] == $past(cnt[IA]))
        else $error("core not reloaded from aux a");

    AST_PWM_B: assert property (
        @(posedge clk) disable iff (!rst_n)
        reload[IB] && !reload[IA] && !wr_cnt[IC] |=> cnt[IC] == $past(cnt[IB]))
        else $error("core not reloaded from aux b");

    AST_GATE: assert property (
        @(posedge clk) disable iff (!rst_n)
        g_tmr[IB].mode == TG_M_GATE_HIGH && !sync2_q[IB] && !ld_en[IB]
        |=> $stable(cnt[IB]))
        else $error("aux b counted with its gate closed");

    AST_PRESCALE: assert property (
        @(posedge clk) disable iff (!rst_n)
        g_tmr[IC].mode == TG_M_TIMER && ctrl_q[IC][`TG_F_RUN] && !ld_en[IC]
        && !ctrl_q[IC][`TG_F_DOWN] && !ctrl_q[IC][`TG_F_EXTDIR]
        |=> cnt[IC] == $past(cnt[IC]) + W'($past(ps_tick[g_tmr[IC].sel])))
        else $error("core timer step does not follow its prescaler tick");

    AST_OUTPIN: assert property (
        @(posedge clk) disable iff (!rst_n)
        !ctrl_q[IC][`TG_F_OUTEN] ##1 !ctrl_q[IC][`TG_F_OUTEN] |-> !toggle_latch_output_pin)
        else $error("toggle latch pin driven while disabled");

    AST_SYNC: assert property (
        @(posedge clk) disable iff (!rst_n)
        pin_rise[IC] |-> $past(sync1_q[IC]) && !$past(sync1_q[IC], 2))
        else $error("edge seen without passing both sync stages");

endmodule : tg_timer_group_one

`default_nettype wire

//--- tg_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module tg_pin_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // requests from the bench
    input  wire logic [2:0] lvl,
    input  wire logic [2:0] dir_lvl,
    input  wire logic [2:0] pulse_go,
    input  wire logic       step_go,
    input  wire logic       step_rev,
    input  wire logic       quad_en,
    // pins toward the timers
    output logic      [2:0] cnt_pin,
    output logic      [2:0] dir_pin,
    output logic            busy
);
    logic [2:0] pc_q [3];
    logic [1:0] ph_q;
    logic [2:0] sw_q;

    // pulses stay 3 clocks each way so a two-flop synchroniser cannot miss them
    always_ff @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (!rst_n || pulse_go[i]) begin
                pc_q[i] <= rst_n ? 3'h6 : 3'h0;
            end else if (pc_q[i] != 3'h0) begin
                pc_q[i] <= pc_q[i] - 3'h1;
            end
        end
    end

    // one sensor step at a time, then a quiet gap
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ph_q <= 2'h0;
            sw_q <= 3'h0;
        end else if (step_go) begin
            ph_q <= step_rev ? ph_q - 2'h1 : ph_q + 2'h1;
            sw_q <= 3'h5;
        end else if (sw_q != 3'h0) begin
            sw_q <= sw_q - 3'h1;
        end
    end

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            cnt_pin[i] = lvl[i] ^ (pc_q[i] >= 3'h4);
        end
        dir_pin = dir_lvl;
        if (quad_en) begin
            // gray sequence: forward motion raises track a before track b
            cnt_pin[1] = ph_q[1] ^ ph_q[0];
            dir_pin[1] = ph_q[1];
        end
    end

    assign busy = (sw_q != 3'h0) || (pc_q[0] != 3'h0) || (pc_q[1] != 3'h0) || (pc_q[2] != 3'h0);
endmodule : tg_pin_model

`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tg_cfg.svh"

module tb import tg_pkg::*;;
    logic        clk, rst_n, cyc, stb, we, wb_ack_o, pin_out, busy, stp, rev, qen;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, wb_dat_o;
    logic [2:0]  lvl, dl, go, cnt_pin, dir_pin;
    int          n_errors, n_compared;
    localparam logic [3:0] RUN = 4'h1, DN = 4'h2, EXT = 4'h4, OEN = 4'h8;
    localparam logic [7:0] CTA = `TG_OFF_CTRL_A, CTC = `TG_OFF_CTRL_CORE, CTB = `TG_OFF_CTRL_B;
    localparam logic [7:0] NA = `TG_OFF_CNT_A, NC = `TG_OFF_CNT_CORE, NB = `TG_OFF_CNT_B;
    localparam logic [7:0] ST = `TG_OFF_STATUS;

    tg_timer_group_one DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .timer_count_gate_input(cnt_pin),
        .timer_direction_input(dir_pin), .toggle_latch_output_pin(pin_out));

    tg_pin_model PM (.clk(clk), .rst_n(rst_n), .lvl(lvl), .dir_lvl(dl), .pulse_go(go),
        .step_go(stp), .step_rev(rev), .quad_en(qen), .cnt_pin(cnt_pin),
        .dir_pin(dir_pin), .busy(busy));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] ctl(input logic [2:0] s, input logic [2:0] m,
                                        input logic [3:0] f);
        return {22'h0, f, m, s};
    endfunction : ctl

    task give_verdict();
        $display("checks %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    task fail_out(input string nm);
        n_errors++;
        $display("[ERR] %s expected done seen timeout", nm);
        give_verdict();
    endtask : fail_out

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // classic single cycle; the request stands until ack is sampled high
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        {cyc, stb, we, sel} <= {2'b11, w, 4'h3};
        adr <= a;
        wdat <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        rdat = wb_dat_o;
        {cyc, stb} <= 2'b00;
        if (k >= 20) fail_out("wb_ack");
    endtask : wb

    task wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr

    // prescaler phase is free running, so timed counts are checked as a range
    task rc(input string nm, input logic [7:0] a, input logic [15:0] lo, input logic [15:0] hi);
        wb(1'b0, a, 32'h0);
        if (lo == hi) check(nm, rdat, {16'h0, lo});
        else check(nm, {31'h0, rdat[15:0] >= lo && rdat[15:0] <= hi
                            && rdat[31:16] == 16'h0}, 32'h1);
    endtask : rc

    task fire(input logic [2:0] p, input logic s, input int n);
        int k;
        repeat (n) begin
            @(posedge clk);
            go <= p;
            stp <= s;
            @(posedge clk);
            go <= 3'h0;
            stp <= 1'b0;
            k = 0;
            do begin
                @(posedge clk);
                k++;
            end while (busy === 1'b1 && k < 20);
            if (k >= 20) fail_out("pin_model");
        end
        repeat (4) @(posedge clk);
    endtask : fire

    task wl(input logic v, output int n);
        n = 0;
        while (pin_out !== v && n < 1000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 1000) fail_out("pwm_pin");
    endtask : wl

    initial begin
        int t, n, hi, lo;
        {rst_n, cyc, stb, we, sel, adr, wdat} = '0;
        {lvl, dl, go, stp, rev, qen} = '0;
        n_errors = 0;
        n_compared = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rc("ctrl_core_rst", CTC, 16'h0, 16'h0);
        rc("cnt_b_rst", NB, 16'h0, 16'h0);
        rc("status_rst", ST, 16'h0, 16'h0);
        rc("unmapped", 8'h1C, 16'h0, 16'h0);
        wr(NC, 32'hFFFFA5C3);
        rc("cnt_width", NC, 16'hA5C3, 16'hA5C3);
        $display("test registers finished");
        for (int s = 0; s < 8; s++) begin
            t = s % 3;
            wr(NA + 8'(t * 4), 32'h0);
            wr(CTA + 8'(t * 4), ctl(3'(s), TG_M_TIMER, RUN));
            repeat (64 << s) @(posedge clk);
            wr(CTA + 8'(t * 4), 32'h0);
            rc("prescale", NA + 8'(t * 4), 16'h7, 16'h9);
        end
        $display("test prescaler finished");
        // aux b counts both latch edges from the internal source
        wr(NB, 32'h0);
        wr(CTB, ctl(3'h7, TG_M_COUNTER, RUN));
        wr(NC, 32'hFFFE);
        wr(CTC, ctl(3'h0, TG_M_TIMER, RUN | OEN));
        repeat (40) @(posedge clk);
        wr(CTC, ctl(3'h0, TG_M_TIMER, OEN));
        rc("wrap_up", NC, 16'h1, 16'h5);
        rc("ovf_flag", ST, 16'h5, 16'h5);
        check("latch_pin", {31'h0, pin_out}, 32'h1);
        wr(ST, 32'hF);
        wr(NC, 32'h1);
        wr(CTC, ctl(3'h0, TG_M_TIMER, RUN | DN | OEN));
        repeat (40) @(posedge clk);
        wr(CTC, ctl(3'h0, TG_M_TIMER, OEN));
        rc("wrap_down", NC, 16'hFFF9, 16'hFFFE);
        rc("unf_flag", ST, 16'h4, 16'h4);
        check("latch_pin", {31'h0, pin_out}, 32'h0);
        wr(ST, 32'hE);
        rc("latch_clock", NB, 16'h2, 16'h2);
        $display("test wrap finished");
        wr(NA, 32'h0);
        wr(CTA, ctl(3'h1, TG_M_COUNTER, RUN));
        fire(3'h1, 1'b0, 5);
        rc("count_rise", NA, 16'h5, 16'h5);
        wr(CTA, ctl(3'h2, TG_M_COUNTER, RUN | DN));
        fire(3'h1, 1'b0, 2);
        rc("count_fall_down", NA, 16'h3, 16'h3);
        dl <= 3'h1;
        wr(CTA, ctl(3'h3, TG_M_COUNTER, RUN | DN | EXT));
        fire(3'h1, 1'b0, 2);
        rc("ext_dir", NA, 16'h7, 16'h7);
        dl <= 3'h0;
        $display("test counter finished");
        wr(NB, 32'h0);
        wr(CTB, ctl(3'h0, TG_M_GATE_HIGH, RUN));
        repeat (200) @(posedge clk);
        rc("gate_shut", NB, 16'h0, 16'h0);
        lvl <= 3'h4;
        repeat (200) @(posedge clk);
        lvl <= 3'h0;
        repeat (100) @(posedge clk);
        rc("gate_high", NB, 16'h16, 16'h1C);
        wr(CTB, ctl(3'h0, TG_M_GATE_LOW, RUN));
        repeat (200) @(posedge clk);
        wr(CTB, 32'h0);
        rc("gate_low", NB, 16'h2F, 16'h35);
        $display("test gated finished");
        wr(NC, 32'h0);
        qen <= 1'b1;
        wr(CTC, ctl(3'h3, TG_M_INCR, RUN));
        fire(3'h0, 1'b1, 8);
        rc("quad_fwd", NC, 16'h8, 16'h8);
        rev <= 1'b1;
        fire(3'h0, 1'b1, 3);
        rc("quad_rev", NC, 16'h5, 16'h5);
        wr(CTC, 32'h0);
        {qen, rev} <= 2'b00;
        $display("test incremental finished");
        wr(NC, 32'h1234);
        wr(NA, 32'h0);
        wr(CTA, ctl(3'h1, TG_M_CAPTURE, RUN));
        fire(3'h1, 1'b0, 1);
        rc("capture", NA, 16'h1234, 16'h1234);
        repeat (50) @(posedge clk);
        rc("capture_hold", NA, 16'h1234, 16'h1234);
        wr(NB, 32'h0ABC);
        wr(CTB, ctl(3'h1, TG_M_RELOAD, RUN));
        fire(3'h4, 1'b0, 1);
        rc("reload", NC, 16'h0ABC, 16'h0ABC);
        rc("reload_hold", NB, 16'h0ABC, 16'h0ABC);
        $display("test capture reload finished");
        wr(NA, 32'hFFF8);
        wr(CTA, ctl(3'h5, TG_M_RELOAD, 4'h0));
        wr(NB, 32'hFFFC);
        wr(CTB, ctl(3'h6, TG_M_RELOAD, 4'h0));
        wr(NC, 32'hFFF0);
        wr(CTC, ctl(3'h0, TG_M_TIMER, RUN | OEN));
        wl(1'b1, n);
        wl(1'b0, hi);
        wl(1'b1, lo);
        check("pwm_high", {31'h0, hi >= 32'h3E && hi <= 32'h42}, 32'h1);
        check("pwm_low", {31'h0, lo >= 32'h1E && lo <= 32'h22}, 32'h1);
        wr(CTC, 32'h0);
        wr(CTA, 32'h0);
        wr(CTB, 32'h0);
        $display("test pwm finished");
        wr(NC, 32'h0);
        wr(NA, 32'hFFFE);
        wr(CTC, ctl(3'h5, TG_M_COUNTER, RUN));
        wr(CTA, ctl(3'h0, TG_M_TIMER, RUN));
        repeat (40) @(posedge clk);
        wr(CTA, 32'h0);
        rc("chain", NC, 16'h1, 16'h1);
        $display("test chain finished");
        give_verdict();
    end
endmodule : tb

`default_nettype wire
